// ===== rtl/sqp_pkg.sv
// Package of constants and types for the arbitrary set-point sequencer
// Function
// - 100 points, one target: voltage or current
// - Run first..last block, N cycles or endless
// - Linear DC ramp plus swept sine
// - Both frequencies zero suppress the sine
// - Sine amplitudes limited to half nominal
// - Manual frequencies limited to ten kilohertz
// - Start phase 0 to 359 degrees
// - DC between amplitude (zero for loaded rows) and nominal minus amplitude
// - Duration from 0.1 ms to 36000 s
// - Frequency sweep rate at least 9.3 per second
// - Refuse tiny amplitude change over long time
// - Every point restarts at its own start level
// - Table moves as all 100 points together
// - Load needs exactly 100 rows of 8 values
// - Separator setting picks column and decimal marks
// - Folder flag and table name prefix required
// - Columns taken in fixed order, time in microseconds
// - Every value range checked, file frequency 1 kHz
// - Table name must match the chosen target
package sqp_pkg;

  localparam int NPTS = 100;
  localparam int NCOLS = 8;
  localparam logic [15:0] NOM_VALUE = 16'h2710;
  localparam logic [13:0] F_MAX_MAN = 14'd10000;
  localparam logic [13:0] F_MAX_FILE = 14'd1000;
  localparam logic [8:0] ANG_MAX = 9'd359;
  localparam logic [35:0] T_MIN_US = 36'd100;
  localparam logic [35:0] T_MAX_US = 36'd36000000000;
  localparam logic [63:0] DF_RATE_X10 = 64'd93;
  localparam logic [63:0] AMP_RATE_MIN = 64'd1;
  localparam logic [63:0] US_PER_S = 64'd1000000;
  localparam logic [9:0] CYC_MAX = 10'd999;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam logic [31:0] PH_PER_HZ = 32'd4295;
  localparam logic [31:0] PH_PER_DEG = 32'd11930465;
  localparam int DIV_BITS = 41;

  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FIRST = 8'h04;
  localparam logic [7:0] OFS_LAST = 8'h08;
  localparam logic [7:0] OFS_CYCLES = 8'h0c;
  localparam logic [7:0] OFS_PT_IDX = 8'h10;
  localparam logic [7:0] OFS_PT_AC = 8'h14;
  localparam logic [7:0] OFS_PT_FREQ = 8'h18;
  localparam logic [7:0] OFS_PT_ANGLE = 8'h1c;
  localparam logic [7:0] OFS_PT_DC = 8'h20;
  localparam logic [7:0] OFS_PT_TLO = 8'h24;
  localparam logic [7:0] OFS_PT_THI = 8'h28;
  localparam logic [7:0] OFS_PT_CMD = 8'h2c;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam logic [7:0] OFS_SETVAL = 8'h34;
  localparam logic [7:0] OFS_POS = 8'h38;
  localparam logic [7:0] OFS_LD_NAME = 8'h3c;
  localparam logic [7:0] OFS_LD_CHAR = 8'h40;
  localparam logic [7:0] OFS_LD_CMD = 8'h44;

  // Control fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_CURR = 1;
  localparam int CTRL_INF = 2;
  localparam int CTRL_SEP = 3;
  localparam int LD_BEGIN = 0;
  localparam int LD_END = 1;
  localparam int LD_FOLDER = 2;
  localparam logic [1:0] CMD_COMMIT = 2'h1;
  localparam logic [1:0] CMD_FETCH = 2'h2;

  // Reset values
  localparam logic [6:0] FIRST_RST = 7'h01;
  localparam logic [6:0] LAST_RST = 7'h64;
  localparam logic [9:0] CYCLES_RST = 10'h001;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } sqp_ahb_in_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } sqp_ahb_out_t;

  typedef struct packed {
    logic [15:0] ac_start_amplitude;
    logic [15:0] ac_end_amplitude;
    logic [13:0] sweep_start_frequency;
    logic [13:0] sweep_end_frequency;
    logic [8:0] angle;
    logic [15:0] dc_start_level;
    logic [15:0] dc_end_level;
    logic [35:0] dur_us;
  } sqp_point_t;

  typedef struct packed {
    logic valid;
    logic target_current;
    logic [15:0] value;
  } sqp_setpoint_t;

  typedef enum logic [2:0] {
    SQ_IDLE = 3'b000,
    SQ_FETCH = 3'b001,
    SQ_PREP = 3'b011,
    SQ_RUN = 3'b010,
    SQ_DONE = 3'b110
  } sqp_state_t;

  typedef enum logic [1:0] {
    LS_IDLE = 2'b00,
    LS_ACTIVE = 2'b01,
    LS_OK = 2'b11,
    LS_FAIL = 2'b10
  } sqp_ld_t;

endpackage : sqp_pkg

// ===== rtl/sqp_sequencer.sv
// Arbitrary set-point sequencer with AHB-Lite registers and table loader
//
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module sqp_sequencer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // AHB-Lite slave
  input wire sqp_pkg::sqp_ahb_in_t bus_i,
  output sqp_pkg::sqp_ahb_out_t bus_o,
  // Set value to power stage
  output sqp_pkg::sqp_setpoint_t setpoint_o
);
  import sqp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic pt_ok(input sqp_point_t p, input logic file);
    logic [15:0] half;
    logic [13:0] fmax;
    logic [13:0] df;
    logic [15:0] da;
    logic ok;
    half = NOM_VALUE >> 1;
    fmax = file ? F_MAX_FILE : F_MAX_MAN;
    df = (p.sweep_end_frequency > p.sweep_start_frequency) ?
         p.sweep_end_frequency - p.sweep_start_frequency : p.sweep_start_frequency - p.sweep_end_frequency;
    da = (p.ac_end_amplitude > p.ac_start_amplitude) ?
         p.ac_end_amplitude - p.ac_start_amplitude : p.ac_start_amplitude - p.ac_end_amplitude;
    ok = (p.ac_start_amplitude <= half) && (p.ac_end_amplitude <= half);
    ok = ok && (p.sweep_start_frequency <= fmax) && (p.sweep_end_frequency <= fmax);
    ok = ok && (p.angle <= ANG_MAX);
    ok = ok && (p.dc_start_level >= (file ? 16'h0000 : p.ac_start_amplitude));
    ok = ok && (p.dc_end_level >= (file ? 16'h0000 : p.ac_end_amplitude));
    ok = ok && (p.dc_start_level <= NOM_VALUE - p.ac_start_amplitude);
    ok = ok && (p.dc_end_level <= NOM_VALUE - p.ac_end_amplitude);
    ok = ok && (p.dur_us >= T_MIN_US) && (p.dur_us <= T_MAX_US);
    if (df != 14'h0000 && 64'(df) * US_PER_S * 64'd10 < DF_RATE_X10 * 64'(p.dur_us)) begin
      ok = 1'b0;
    end
    if (da != 16'h0000 && 64'(da) * US_PER_S < AMP_RATE_MIN * 64'(p.dur_us)) begin
      ok = 1'b0;
    end
    return ok;
  endfunction : pt_ok

  function automatic logic [17:0] lerp(input logic [15:0] s, input logic [15:0] e, input logic [15:0] f);
    logic signed [16:0] d;
    logic signed [33:0] p;
    d = $signed({1'b0, e}) - $signed({1'b0, s});
    p = 34'(d) * $signed({18'h00000, f});
    return 18'($signed({2'b00, s}) + 18'(p >>> 16));
  endfunction : lerp

  ////////////////////////////////////////////////////////////////////////////
  // Storage and state
  sqp_point_t tbl [2][NPTS];
  sqp_point_t stage_r;
  sqp_point_t pt_r;
  sqp_point_t row_r;
  sqp_point_t row_nxt;
  sqp_setpoint_t set_r;
  sqp_state_t state_r;
  sqp_ld_t ld_r;
  logic [31:0] rdata_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic ahb_acc;
  logic run_r, curr_r, inf_r, sep_r, bank_r, point_err_r;
  logic [6:0] first_r, last_r, idx_r, cur_r, row_cnt_r;
  logic [9:0] cycles_r, cyc_cnt_r;
  logic [35:0] t_r;
  logic [6:0] tick_r;
  logic [40:0] rem_r, recip_r;
  logic [5:0] div_r;
  logic [31:0] phase_r;
  logic [2:0] name_cnt_r, col_r;
  logic name_ok_r, frac_r, got_dig_r;
  logic [1:0] fcnt_r;
  logic [39:0] acc_r;
  logic start_req, stop_req, commit_ok, fetch_req, ld_char, ld_begin, ld_end;
  logic [7:0] ch, up;
  logic [31:0] wd;
  logic [41:0] rem_sh;
  logic [39:0] scaled;
  logic val_bad, push, row_end, row_bad;

  assign ahb_acc = bus_i.hsel && bus_i.htrans[1] && bus_i.hready;
  assign wd = bus_i.hwdata;
  assign bus_o.hrdata = rdata_r;
  assign bus_o.hreadyout = 1'b1;
  assign bus_o.hresp = 1'b0;
  assign setpoint_o = set_r;

  ////////////////////////////////////////////////////////////////////////////
  // Bus phases
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= ahb_acc && bus_i.hwrite;
      wr_addr_r <= bus_i.haddr[7:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h00000000;
    end else if (ahb_acc && !bus_i.hwrite) begin
      unique case (bus_i.haddr[7:0])
        OFS_CTRL: rdata_r <= {28'h0000000, sep_r, inf_r, curr_r, run_r};
        OFS_FIRST: rdata_r <= {25'h0000000, first_r};
        OFS_LAST: rdata_r <= {25'h0000000, last_r};
        OFS_CYCLES: rdata_r <= {22'h000000, cycles_r};
        OFS_PT_IDX: rdata_r <= {25'h0000000, idx_r};
        OFS_PT_AC: rdata_r <= {stage_r.ac_end_amplitude, stage_r.ac_start_amplitude};
        OFS_PT_FREQ: rdata_r <= {2'b00, stage_r.sweep_end_frequency, 2'b00, stage_r.sweep_start_frequency};
        OFS_PT_ANGLE: rdata_r <= {23'h000000, stage_r.angle};
        OFS_PT_DC: rdata_r <= {stage_r.dc_end_level, stage_r.dc_start_level};
        OFS_PT_TLO: rdata_r <= stage_r.dur_us[31:0];
        OFS_PT_THI: rdata_r <= {28'h0000000, stage_r.dur_us[35:32]};
        OFS_STATUS: rdata_r <= {24'h000000, bank_r, ld_r, point_err_r, 1'b0, state_r};
        OFS_SETVAL: rdata_r <= {15'h0000, set_r.valid, set_r.value};
        OFS_POS: rdata_r <= {6'h00, cyc_cnt_r, 9'h000, cur_r + 7'h01};
        default: rdata_r <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  assign start_req = wr_pend_r && wr_addr_r == OFS_CTRL && wd[CTRL_RUN] && !run_r;
  assign stop_req = wr_pend_r && wr_addr_r == OFS_CTRL && !wd[CTRL_RUN];
  assign commit_ok = wr_pend_r && wr_addr_r == OFS_PT_CMD && wd[1:0] == CMD_COMMIT && pt_ok(stage_r, 1'b0);
  assign fetch_req = wr_pend_r && wr_addr_r == OFS_PT_CMD && wd[1:0] == CMD_FETCH;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      curr_r <= 1'b0;
      inf_r <= 1'b0;
      sep_r <= 1'b0;
      first_r <= FIRST_RST;
      last_r <= LAST_RST;
      cycles_r <= CYCLES_RST;
      idx_r <= FIRST_RST;
    end else if (wr_pend_r) begin
      unique case (wr_addr_r)
        OFS_CTRL: begin
          if (!run_r) begin
            curr_r <= wd[CTRL_CURR];
            inf_r <= wd[CTRL_INF];
            sep_r <= wd[CTRL_SEP];
          end
        end
        OFS_FIRST: if (!run_r && wd[6:0] >= 7'd1 && wd[6:0] <= last_r && wd[31:7] == 25'h0) first_r <= wd[6:0];
        OFS_LAST: if (!run_r && wd[6:0] >= first_r && wd[6:0] <= 7'(NPTS) && wd[31:7] == 25'h0) last_r <= wd[6:0];
        OFS_CYCLES: if (wd[9:0] >= 10'd1 && wd[9:0] <= CYC_MAX && wd[31:10] == 22'h0) cycles_r <= wd[9:0];
        OFS_PT_IDX: if (wd[6:0] >= 7'd1 && wd[6:0] <= 7'(NPTS) && wd[31:7] == 25'h0) idx_r <= wd[6:0];
        default: ;
      endcase
    end
  end

  // Staging point and its verdict
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage_r <= '0;
      point_err_r <= 1'b0;
    end else if (fetch_req) begin
      stage_r <= tbl[bank_r][idx_r - 7'd1];
    end else if (wr_pend_r) begin
      unique case (wr_addr_r)
        OFS_PT_AC: {stage_r.ac_end_amplitude, stage_r.ac_start_amplitude} <= wd;
        OFS_PT_FREQ: {stage_r.sweep_end_frequency, stage_r.sweep_start_frequency} <= {wd[29:16], wd[13:0]};
        OFS_PT_ANGLE: stage_r.angle <= wd[8:0];
        OFS_PT_DC: {stage_r.dc_end_level, stage_r.dc_start_level} <= wd;
        OFS_PT_TLO: stage_r.dur_us[31:0] <= wd;
        OFS_PT_THI: stage_r.dur_us[35:32] <= wd[3:0];
        OFS_PT_CMD: if (wd[1:0] == CMD_COMMIT) point_err_r <= !commit_ok;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table loader: character stream parser
  assign ch = wd[7:0];
  assign up = (ch >= 8'h61 && ch <= 8'h7a) ? ch - 8'h20 : ch;
  assign ld_char = wr_pend_r && wr_addr_r == OFS_LD_CHAR && ld_r == LS_ACTIVE;
  assign ld_begin = wr_pend_r && wr_addr_r == OFS_LD_CMD && wd[LD_BEGIN];
  assign ld_end = wr_pend_r && wr_addr_r == OFS_LD_CMD && wd[LD_END] && ld_r == LS_ACTIVE;
  assign push = ld_char && (ch == (sep_r ? 8'h2c : 8'h3b) || ch == 8'h0a);
  assign row_end = ld_char && ch == 8'h0a;

  always_comb begin
    unique case (fcnt_r)
      2'd0: scaled = acc_r * 40'd100;
      2'd1: scaled = acc_r * 40'd10;
      default: scaled = acc_r;
    endcase
    row_nxt = row_r;
    val_bad = !got_dig_r;
    unique case (col_r)
      3'd0: begin row_nxt.ac_start_amplitude = scaled[15:0]; val_bad = val_bad || scaled[39:16] != 24'h0; end
      3'd1: begin row_nxt.ac_end_amplitude = scaled[15:0]; val_bad = val_bad || scaled[39:16] != 24'h0; end
      3'd2: begin row_nxt.sweep_start_frequency = acc_r[13:0]; val_bad = val_bad || frac_r || acc_r[39:14] != 26'h0; end
      3'd3: begin row_nxt.sweep_end_frequency = acc_r[13:0]; val_bad = val_bad || frac_r || acc_r[39:14] != 26'h0; end
      3'd4: begin row_nxt.angle = acc_r[8:0]; val_bad = val_bad || frac_r || acc_r[39:9] != 31'h0; end
      3'd5: begin row_nxt.dc_start_level = scaled[15:0]; val_bad = val_bad || scaled[39:16] != 24'h0; end
      3'd6: begin row_nxt.dc_end_level = scaled[15:0]; val_bad = val_bad || scaled[39:16] != 24'h0; end
      default: begin row_nxt.dur_us = acc_r[35:0]; val_bad = val_bad || frac_r || acc_r[39:36] != 4'h0; end
    endcase
    row_bad = row_end ? (col_r != 3'(NCOLS - 1) || row_cnt_r >= 7'(NPTS) || !pt_ok(row_nxt, 1'b1))
                      : (col_r == 3'(NCOLS - 1));
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      name_cnt_r <= 3'd0;
      name_ok_r <= 1'b0;
    end else if (wr_pend_r && wr_addr_r == OFS_LD_NAME) begin
      if (name_cnt_r == 3'd0) begin
        name_ok_r <= up == 8'h57;
      end else begin
        unique case (name_cnt_r)
          3'd1: name_ok_r <= name_ok_r && up == 8'h41;
          3'd2: name_ok_r <= name_ok_r && up == 8'h56;
          3'd3: name_ok_r <= name_ok_r && up == 8'h45;
          3'd4: name_ok_r <= name_ok_r && up == 8'h5f;
          3'd5: name_ok_r <= name_ok_r && up == (curr_r ? 8'h49 : 8'h55);
          default: ;
        endcase
      end
      if (name_cnt_r < 3'd6) name_cnt_r <= name_cnt_r + 3'd1;
    end else if (ld_begin) begin
      name_cnt_r <= 3'd0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ld_r <= LS_IDLE;
      bank_r <= 1'b0;
      row_cnt_r <= 7'd0;
      col_r <= 3'd0;
      acc_r <= 40'h0;
      frac_r <= 1'b0;
      fcnt_r <= 2'd0;
      got_dig_r <= 1'b0;
      row_r <= '0;
    end else if (ld_begin) begin
      ld_r <= (wd[LD_FOLDER] && name_ok_r && name_cnt_r == 3'd6 && !run_r) ? LS_ACTIVE : LS_FAIL;
      row_cnt_r <= 7'd0;
      col_r <= 3'd0;
      acc_r <= 40'h0;
      frac_r <= 1'b0;
      fcnt_r <= 2'd0;
      got_dig_r <= 1'b0;
    end else if (ld_end) begin
      ld_r <= (row_cnt_r == 7'(NPTS) && col_r == 3'd0) ? LS_OK : LS_FAIL;
      if (row_cnt_r == 7'(NPTS) && col_r == 3'd0) bank_r <= !bank_r;
    end else if (ld_char) begin
      if (ch >= 8'h30 && ch <= 8'h39) begin
        acc_r <= 40'(acc_r * 40'd10) + {32'h0, ch - 8'h30};
        got_dig_r <= 1'b1;
        if (frac_r) fcnt_r <= fcnt_r + 2'd1;
        if (frac_r && fcnt_r == 2'd2) ld_r <= LS_FAIL;
      end else if (ch == (sep_r ? 8'h2e : 8'h2c) && !push) begin
        if (frac_r) ld_r <= LS_FAIL;
        frac_r <= 1'b1;
      end else if (push) begin
        if (val_bad || row_bad) ld_r <= LS_FAIL;
        row_r <= row_nxt;
        col_r <= row_end ? 3'd0 : col_r + 3'd1;
        if (row_end) row_cnt_r <= row_cnt_r + 7'd1;
        acc_r <= 40'h0;
        frac_r <= 1'b0;
        fcnt_r <= 2'd0;
        got_dig_r <= 1'b0;
      end else if (ch != 8'h0d) begin
        ld_r <= LS_FAIL;
      end
    end
  end

  // Table writes: manual commit to live bank, load to shadow bank
  always_ff @(posedge clk_sys) begin
    if (commit_ok) tbl[bank_r][idx_r - 7'd1] <= stage_r;
    if (row_end && !val_bad && !row_bad) tbl[!bank_r][row_cnt_r] <= row_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  logic [15:0] frac;
  logic [75:0] prod;
  logic [17:0] dc_now, amp_now, f_now;
  logic [15:0] sin_mag;
  logic [29:0] sq;
  logic signed [33:0] ac_now;
  logic signed [19:0] sum;
  logic last_tick;

  assign prod = 76'(t_r) * 76'(recip_r);
  assign frac = prod[39:24];
  assign dc_now = lerp(pt_r.dc_start_level, pt_r.dc_end_level, frac);
  assign amp_now = lerp(pt_r.ac_start_amplitude, pt_r.ac_end_amplitude, frac);
  assign f_now = lerp({2'b00, pt_r.sweep_start_frequency}, {2'b00, pt_r.sweep_end_frequency}, frac);
  assign sq = 30'(phase_r[30:16]) * 30'(15'h7fff - phase_r[30:16]);
  assign sin_mag = (sq[29:13] > 17'h7fff) ? 16'h7fff : {1'b0, sq[27:13]};
  assign ac_now = (pt_r.sweep_start_frequency == 14'h0 && pt_r.sweep_end_frequency == 14'h0) ? 34'sd0
                : (34'($signed({1'b0, amp_now[15:0]}) * $signed({phase_r[31] ? -17'(sin_mag) : 17'(sin_mag)})) >>> 15);
  assign sum = $signed({2'b00, dc_now}) + 20'(ac_now);
  assign last_tick = tick_r == 7'(TICK_CYC - 1);
  assign rem_sh = {rem_r, (div_r == 6'(DIV_BITS))};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= SQ_IDLE;
      run_r <= 1'b0;
      cur_r <= 7'd0;
      cyc_cnt_r <= 10'd0;
      pt_r <= '0;
      t_r <= 36'h0;
      tick_r <= 7'd0;
      rem_r <= 41'h0;
      recip_r <= 41'h0;
      div_r <= 6'd0;
      phase_r <= 32'h0;
    end else if (stop_req) begin
      state_r <= SQ_IDLE;
      run_r <= 1'b0;
    end else begin
      unique case (state_r)
        SQ_IDLE, SQ_DONE: begin
          if (start_req) begin
            run_r <= 1'b1;
            cur_r <= first_r - 7'd1;
            cyc_cnt_r <= 10'd1;
            state_r <= SQ_FETCH;
          end
        end
        SQ_FETCH: begin
          pt_r <= tbl[bank_r][cur_r];
          rem_r <= 41'h0;
          recip_r <= 41'h0;
          div_r <= 6'(DIV_BITS);
          state_r <= SQ_PREP;
        end
        SQ_PREP: begin
          if (42'(rem_sh) >= 42'(pt_r.dur_us)) begin
            rem_r <= 41'(rem_sh - 42'(pt_r.dur_us));
            recip_r <= {recip_r[39:0], 1'b1};
          end else begin
            rem_r <= rem_sh[40:0];
            recip_r <= {recip_r[39:0], 1'b0};
          end
          div_r <= div_r - 6'd1;
          if (div_r == 6'd1) begin
            t_r <= 36'h0;
            tick_r <= 7'd0;
            phase_r <= 32'(pt_r.angle * PH_PER_DEG);
            state_r <= SQ_RUN;
          end
        end
        SQ_RUN: begin
          tick_r <= last_tick ? 7'd0 : tick_r + 7'd1;
          if (last_tick) begin
            t_r <= t_r + 36'h1;
            phase_r <= phase_r + 32'(f_now[13:0] * PH_PER_HZ);
            if (t_r + 36'h1 >= pt_r.dur_us) begin
              state_r <= SQ_FETCH;
              if (cur_r == last_r - 7'd1) begin
                cur_r <= first_r - 7'd1;
                if (!inf_r && cyc_cnt_r >= cycles_r) begin
                  state_r <= SQ_DONE;
                  run_r <= 1'b0;
                end else if (!inf_r) begin
                  cyc_cnt_r <= cyc_cnt_r + 10'd1;
                end
              end else begin
                cur_r <= cur_r + 7'd1;
              end
            end
          end
        end
        default: state_r <= SQ_IDLE;
      endcase
    end
  end

  // Set value output
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      set_r <= '0;
    end else begin
      set_r.target_current <= curr_r;
      set_r.valid <= run_r;
      if (state_r == SQ_RUN) begin
        set_r.value <= (sum < 0) ? 16'h0000 : (sum > $signed({4'h0, NOM_VALUE})) ? NOM_VALUE : sum[15:0];
      end
    end
  end

endmodule : sqp_sequencer

// ===== tb/sqp_seq_chk.sv
// Port checker for the set-point sequencer
`timescale 1ns/1ps
module sqp_seq_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Bus and set value
  input wire sqp_pkg::sqp_ahb_in_t bus_i,
  input wire sqp_pkg::sqp_ahb_out_t bus_o,
  input wire sqp_pkg::sqp_setpoint_t setpoint_o
);
  import sqp_pkg::*;
  logic ap;
  logic wc_r;
  logic ru_r;
  assign ap = bus_i.hsel && bus_i.htrans[1] && bus_i.hready;
  // Data phase markers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wc_r <= 1'b0;
      ru_r <= 1'b0;
    end else begin
      wc_r <= ap && bus_i.hwrite && bus_i.haddr[7:0] == OFS_CTRL;
      ru_r <= ap && !bus_i.hwrite && bus_i.haddr[7:0] > 8'h47;
    end
  end
  ////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_rdy; bus_o.hreadyout; endproperty
  a_rdy: assert property (p_rdy) else $error("hreadyout low");
  property p_resp; !bus_o.hresp; endproperty
  a_resp: assert property (p_resp) else $error("hresp not okay");
  property p_unm; ru_r |-> bus_o.hrdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_rng; setpoint_o.valid |-> setpoint_o.value <= NOM_VALUE; endproperty
  a_rng: assert property (p_rng) else $error("set value above nominal");
  property p_tgt; setpoint_o.valid && $past(setpoint_o.valid) |-> $stable(setpoint_o.target_current); endproperty
  a_tgt: assert property (p_tgt) else $error("target changed in run");
  property p_hold; !setpoint_o.valid && !$past(setpoint_o.valid) |-> $stable(setpoint_o.value); endproperty
  a_hold: assert property (p_hold) else $error("set value moved while idle");
  property p_start; wc_r && bus_i.hwdata[0] && !setpoint_o.valid |-> ##[1:3] setpoint_o.valid; endproperty
  a_start: assert property (p_start) else $error("run did not start");
  property p_stop; wc_r && !bus_i.hwdata[0] |-> ##[1:3] !setpoint_o.valid; endproperty
  a_stop: assert property (p_stop) else $error("run did not stop");
  c_go: cover property ($rose(setpoint_o.valid));
  c_end: cover property ($fell(setpoint_o.valid));
  c_unm: cover property (ru_r);
endmodule : sqp_seq_chk
bind sqp_sequencer sqp_seq_chk u_chk (.clk_sys(clk_sys), .rst(rst), .bus_i(bus_i), .bus_o(bus_o),
  .setpoint_o(setpoint_o));

// ===== tb/sqp_stage_model.sv
// Power stage set-value input model
`timescale 1ns/1ps
module sqp_stage_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Set value
  input wire sqp_pkg::sqp_setpoint_t setpoint_i
);
  import sqp_pkg::*;
  logic [15:0] seen [$];
  logic [15:0] last_r;
  logic tgt_r;
  // Logs each new level while running
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      last_r <= 16'h0;
      tgt_r <= 1'b0;
    end else if (setpoint_i.valid && setpoint_i.value !== last_r) begin
      seen.push_back(setpoint_i.value);
      last_r <= setpoint_i.value;
      tgt_r <= setpoint_i.target_current;
    end
  end
endmodule : sqp_stage_model

// ===== tb/tb_top.sv
// Testbench for the set-point sequencer
`timescale 1ns/1ps
module tb_top;
  import sqp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  sqp_ahb_in_t bi = '0;
  sqp_ahb_out_t bo;
  sqp_setpoint_t sp;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] q;
  logic b;
  string row_a = "1;2;3;4;5;6;7;200";
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  sqp_sequencer dut (.clk_sys(clk_sys), .rst(rst), .bus_i({bi[71:1], bo.hreadyout}), .bus_o(bo), .setpoint_o(sp));
  sqp_stage_model stage (.clk_sys(clk_sys), .rst(rst), .setpoint_i(sp));
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 95000) begin
      miscompares++;
      finish_test();
    end
  end
  ////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d);
    bi.hsel <= 1'b1;
    bi.haddr <= {24'h0, a};
    bi.htrans <= 2'h2;
    bi.hwrite <= w;
    bi.hsize <= 3'h2;
    do @(posedge clk_sys); while (bo.hreadyout !== 1'b1);
    bi.hsel <= 1'b0;
    bi.htrans <= 2'h0;
    bi.hwdata <= d;
    do @(posedge clk_sys); while (bo.hreadyout !== 1'b1);
    q = bo.hrdata;
  endtask : acc
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    acc(a, 1'b0, 32'h0);
    chk(nm, e, q & m);
  endtask : rdc
  task automatic pt(input logic [31:0] ac, fq, dc, input logic [8:0] an, input logic [35:0] t, input logic e);
    acc(OFS_PT_AC, 1'b1, ac);
    acc(OFS_PT_FREQ, 1'b1, fq);
    acc(OFS_PT_ANGLE, 1'b1, {23'h0, an});
    acc(OFS_PT_DC, 1'b1, dc);
    acc(OFS_PT_TLO, 1'b1, t[31:0]);
    acc(OFS_PT_THI, 1'b1, {28'h0, t[35:32]});
    acc(OFS_PT_CMD, 1'b1, 32'h1);
    rdc("point_err", OFS_STATUS, 32'h10, {27'h0, e, 4'h0});
  endtask : pt
  task automatic str(input logic [7:0] a, input string s);
    for (int i = 0; i < s.len(); i++) acc(a, 1'b1, {24'h0, s[i]});
  endtask : str
  task automatic load(input logic [31:0] ctl, bc, input string nm, r, input int n, input logic [1:0] e);
    acc(OFS_CTRL, 1'b1, ctl);
    str(OFS_LD_NAME, nm);
    acc(OFS_LD_CMD, 1'b1, bc);
    for (int k = 0; k < n; k++) begin
      str(OFS_LD_CHAR, r);
      acc(OFS_LD_CHAR, 1'b1, 32'h0a);
    end
    acc(OFS_LD_CMD, 1'b1, 32'h2);
    rdc("load_state", OFS_STATUS, 32'h60, {25'h0, e, 5'h0});
  endtask : load
  task automatic wv(input logic v);
    for (int n = 0; n < 60000 && sp.valid !== v; n++) @(posedge clk_sys);
    chk("valid", {31'h0, v}, {31'h0, sp.valid});
  endtask : wv
  ////////////////////
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rdc("first", OFS_FIRST, 32'h7f, 32'h1);
    rdc("last", OFS_LAST, 32'h7f, 32'h64);
    rdc("cycles", OFS_CYCLES, 32'h3ff, 32'h1);
    rdc("unmapped", 8'h48, '1, 32'h0);
    $display("test reset done");
    acc(OFS_STATUS, 1'b0, 32'h0);
    b = q[7];
    load(32'h0, 32'h5, "WaVe_U", row_a, 100, 2'h3);
    rdc("bank", OFS_STATUS, 32'h80, {24'h0, ~b, 7'h0});
    acc(OFS_PT_CMD, 1'b1, 32'h2);
    rdc("pt_ac", OFS_PT_AC, '1, 32'h00c80064);
    rdc("pt_freq", OFS_PT_FREQ, 32'h3fff3fff, 32'h00040003);
    rdc("pt_angle", OFS_PT_ANGLE, 32'h1ff, 32'h5);
    rdc("pt_dc", OFS_PT_DC, '1, 32'h02bc0258);
    rdc("pt_time", OFS_PT_TLO, '1, 32'hc8);
    load(32'h0, 32'h5, "wave_u", row_a, 99, 2'h2);
    load(32'h2, 32'h5, "wave_u", row_a, 100, 2'h2);
    load(32'h0, 32'h1, "wave_u", row_a, 100, 2'h2);
    load(32'h0, 32'h5, "wave_u", "0;0;1001;0;0;0;0;100", 100, 2'h2);
    load(32'ha, 32'h5, "wave_i", "1.5,2,3,4,5,6,7,300", 100, 2'h3);
    acc(OFS_PT_CMD, 1'b1, 32'h2);
    rdc("pt_ac", OFS_PT_AC, 32'hffff, 32'h96);
    $display("test loader done");
    pt(32'h13881388, 32'h0, 32'h13881388, 9'h0, 36'h64, 1'b0);
    pt(32'h13891389, 32'h0, 32'h13891389, 9'h0, 36'h64, 1'b1);
    pt(32'h0, 32'h27102710, 32'h0, 9'h0, 36'h64, 1'b0);
    pt(32'h0, 32'h27112711, 32'h0, 9'h0, 36'h64, 1'b1);
    pt(32'h0, 32'h0, 32'h0, 9'h167, 36'h64, 1'b0);
    pt(32'h0, 32'h0, 32'h0, 9'h168, 36'h64, 1'b1);
    pt(32'h00640064, 32'h0, 32'h26ac0064, 9'h0, 36'h64, 1'b0);
    pt(32'h00640064, 32'h0, 32'h00630063, 9'h0, 36'h64, 1'b1);
    pt(32'h00640064, 32'h0, 32'h26ad26ad, 9'h0, 36'h64, 1'b1);
    pt(32'h0, 32'h0, 32'h0, 9'h0, 36'h63, 1'b1);
    pt(32'h0, 32'h0, 32'h0, 9'h0, 36'h861c46800, 1'b0);
    pt(32'h0, 32'h0, 32'h0, 9'h0, 36'h861c46801, 1'b1);
    pt(32'h0, 32'h000b0001, 32'h0, 9'h0, 36'h4c4b40, 1'b1);
    pt(32'h0, 32'h000b0001, 32'h0, 9'h0, 36'hf4240, 1'b0);
    pt(32'h00010000, 32'h0, 32'h00010001, 9'h0, 36'h1e8480, 1'b1);
    pt(32'h00010000, 32'h0, 32'h00010001, 9'h0, 36'hf4240, 1'b0);
    $display("test point limits done");
    pt(32'h01f401f4, 32'h0, 32'h03e803e8, 9'h5a, 36'h64, 1'b0);
    acc(OFS_PT_IDX, 1'b1, 32'h2);
    pt(32'h0, 32'h0, 32'h0bb80bb8, 9'h0, 36'h64, 1'b0);
    acc(OFS_LAST, 1'b1, 32'h2);
    acc(OFS_FIRST, 1'b1, 32'h3);
    rdc("first", OFS_FIRST, 32'h7f, 32'h1);
    acc(OFS_LAST, 1'b1, 32'h65);
    rdc("last", OFS_LAST, 32'h7f, 32'h2);
    acc(OFS_CYCLES, 1'b1, 32'h3e8);
    acc(OFS_CYCLES, 1'b1, 32'h2);
    rdc("cycles", OFS_CYCLES, 32'h3ff, 32'h2);
    stage.seen.delete();
    acc(OFS_CTRL, 1'b1, 32'h3);
    wv(1'b1);
    wv(1'b0);
    chk("levels", 32'h4, stage.seen.size());
    for (int i = 0; i < 4; i++) chk("level", (i % 2) ? 32'hbb8 : 32'h3e8, {16'h0, stage.seen[i]});
    chk("target", 32'h1, {31'h0, stage.tgt_r});
    $display("test run done");
    acc(OFS_CYCLES, 1'b1, 32'h1);
    stage.seen.delete();
    acc(OFS_CTRL, 1'b1, 32'h5);
    for (int n = 0; n < 40000 && stage.seen.size() < 3; n++) @(posedge clk_sys);
    chk("endless", 32'h3e8, {16'h0, stage.seen[2]});
    chk("target", 32'h0, {31'h0, stage.tgt_r});
    acc(OFS_CTRL, 1'b1, 32'h0);
    wv(1'b0);
    $display("test endless done");
    finish_test();
  end
endmodule : tb_top
